// ### agc_defs.svh
/*
 Register indices, reset values, write masks, field positions, codes and
 timing constants of the gain loop control block.
 Assumes it is included by its bare name by every file that needs it.
*/
`ifndef AGC_DEFS_SVH
`define AGC_DEFS_SVH
// Register indices; the byte address on the bus is four times the index
`define AGC_IDX_K2HI 10'h030
`define AGC_IDX_PEAK 10'h031
`define AGC_IDX_SF 10'h032
`define AGC_IDX_CFG0 10'h033
`define AGC_IDX_STAT 10'h040
`define AGC_RST_PEAK 8'h42
`define AGC_RST_SF 8'h00
`define AGC_RST_CFG0 8'h2b
`define AGC_RST_K2HI 8'h00
`define AGC_MASK_PEAK 8'h77
`define AGC_MASK_SF 8'h3f
`define AGC_MASK_CFG0 8'h7f
`define AGC_MASK_K2HI 8'h0f
`define AGC_UP_MSB 6
`define AGC_UP_LSB 4
`define AGC_DN_MSB 2
`define AGC_DN_LSB 0
`define AGC_RESTART_BIT 5
`define AGC_FRZ_MSB 4
`define AGC_FRZ_LSB 2
`define AGC_START_MSB 1
`define AGC_START_LSB 0
`define AGC_DGC_MSB 6
`define AGC_DGC_LSB 4
`define AGC_HYS_MSB 3
`define AGC_HYS_LSB 2
`define AGC_GAIN_MSB 1
`define AGC_GAIN_LSB 0
`define AGC_K2HI_MSB 3
`define AGC_K2HI_LSB 0
`define AGC_START_OFF 2'h0
`define AGC_START_DIRECT 2'h1
`define AGC_START_RSSI 2'h2
`define AGC_START_RECOG 2'h3
`define AGC_FRZ_STAY 3'h0
`define AGC_FRZ_RSSI 3'h1
`define AGC_FRZ_RECOG 3'h2
`define AGC_FRZ_SYNC 3'h3
`define AGC_FRZ_MANUAL 3'h4
`define AGC_GAIN_0DB 2'h0
`define AGC_GAIN_15DB 2'h1
`define AGC_GAIN_30DB 2'h2
`define AGC_GAIN_AUTO 2'h3
`define AGC_ATTEN_0 5'h00
`define AGC_ATTEN_15 5'h0f
`define AGC_ATTEN_30 5'h1e
// Hysteresis in 0.1 dB units
`define AGC_HYS_0 9'h080
`define AGC_HYS_1 9'h0ab
`define AGC_HYS_2 9'h0d5
`define AGC_HYS_3 9'h100
// Gain correction in 0.5 dB units, 14.5 dB at code zero
`define AGC_DGC_BASE 6'h1d
`define AGC_UP_OFS 4'h1
`define AGC_DN_OFS 4'h2
`define AGC_BASE_DIV 3'h4
`define AGC_RESP_OKAY 2'h0
`define AGC_RESP_SLVERR 2'h2
`endif

// ### agc_pkg.sv
/*
 Types of the gain loop control block.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package agc_pkg;
	typedef enum logic [2:0] {
		st_off, st_wait, st_run, st_delay, st_frozen
	} agc_state_t;
	typedef logic [1:0] agc_resp_t;
endpackage
`default_nettype wire

// ### agc_cfg_if.sv
/*
 Carrier between the register slave and the loop core.
 Assumes one clock domain; sf_wr is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
interface agc_cfg_if;
	logic [7:0] peak;
	logic [7:0] sf;
	logic [7:0] cfg0;
	logic [7:0] k2hi;
	logic sf_wr;
	logic [7:0] status;
	modport regs(output peak, output sf, output cfg0, output k2hi,
		output sf_wr, input status);
	modport core(input peak, input sf, input cfg0, input k2hi,
		input sf_wr, output status);
endinterface
`default_nettype wire

// ### agc_axil_regs.sv
/*
 AXI4-Lite slave holding the configuration registers.
 Assumes a master that keeps one write and one read under way at most.
*/
`timescale 1ns/1ps
`default_nettype none
`include "agc_defs.svh"
module agc_axil_regs (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output agc_pkg::agc_resp_t s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output agc_pkg::agc_resp_t s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Core side
	agc_cfg_if.regs cfg
);
	import agc_pkg::*;
	logic aw_full_r, w_full_r, do_wr, wr_hit, rd_hit;
	logic [9:0] aw_idx_r;
	logic [7:0] wbyte_r, rd_byte;
	logic wstb_r;
	logic [7:0] peak_r, sf_r, cfg0_r, k2hi_r;

	assign s_axi_awready_o = !aw_full_r && !s_axi_bvalid_o;
	assign s_axi_wready_o = !w_full_r && !s_axi_bvalid_o;
	assign s_axi_arready_o = !s_axi_rvalid_o;
	assign do_wr = aw_full_r && w_full_r;
	assign wr_hit = aw_idx_r == `AGC_IDX_PEAK || aw_idx_r == `AGC_IDX_SF ||
		aw_idx_r == `AGC_IDX_CFG0 || aw_idx_r == `AGC_IDX_K2HI;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_idx_r <= 10'h000;
			wbyte_r <= 8'h00;
			wstb_r <= 1'b0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_full_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr_i[11:2];
			end else if (do_wr) begin
				aw_full_r <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_full_r <= 1'b1;
				wbyte_r <= s_axi_wdata_i[7:0];
				wstb_r <= s_axi_wstrb_i[0];
			end else if (do_wr) begin
				w_full_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `AGC_RESP_OKAY;
		end else if (do_wr) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= wr_hit ? `AGC_RESP_OKAY : `AGC_RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// Only byte lane 0 carries data; reserved bits are masked to zero
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			peak_r <= `AGC_RST_PEAK;
			sf_r <= `AGC_RST_SF;
			cfg0_r <= `AGC_RST_CFG0;
			k2hi_r <= `AGC_RST_K2HI;
			cfg.sf_wr <= 1'b0;
		end else begin
			cfg.sf_wr <= do_wr && wstb_r && aw_idx_r == `AGC_IDX_SF;
			if (do_wr && wstb_r) begin
				if (aw_idx_r == `AGC_IDX_PEAK)
					peak_r <= wbyte_r & `AGC_MASK_PEAK;
				if (aw_idx_r == `AGC_IDX_SF)
					sf_r <= wbyte_r & `AGC_MASK_SF;
				if (aw_idx_r == `AGC_IDX_CFG0)
					cfg0_r <= wbyte_r & `AGC_MASK_CFG0;
				if (aw_idx_r == `AGC_IDX_K2HI)
					k2hi_r <= wbyte_r & `AGC_MASK_K2HI;
			end
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_byte = 8'h00;
		case (s_axi_araddr_i[11:2])
			`AGC_IDX_PEAK: rd_byte = peak_r;
			`AGC_IDX_SF: rd_byte = sf_r;
			`AGC_IDX_CFG0: rd_byte = cfg0_r;
			`AGC_IDX_K2HI: rd_byte = k2hi_r;
			`AGC_IDX_STAT: rd_byte = cfg.status;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= `AGC_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= {24'h00_0000, rd_byte};
			s_axi_rresp_o <= rd_hit ? `AGC_RESP_OKAY : `AGC_RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	assign cfg.peak = peak_r;
	assign cfg.sf = sf_r;
	assign cfg.cfg0 = cfg0_r;
	assign cfg.k2hi = k2hi_r;
endmodule // agc_axil_regs
`default_nettype wire

// ### agc_freeze_timer.sv
/*
 Freeze delay counter: base tick is four predecimation strobes, and
 done rises once the number of base ticks equals the division ratio.
 Assumes en_i is held high for the whole wait and low otherwise.
*/
`timescale 1ns/1ps
`default_nettype none
`include "agc_defs.svh"
module agc_freeze_timer (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Control
	input wire logic en_i,
	input wire logic strobe_i,
	input wire logic [7:0] ratio_i,
	output logic done_o
);
	logic [1:0] pre_r;
	logic [7:0] cnt_r;
	logic tick;

	assign tick = en_i && strobe_i &&
		pre_r == 2'(`AGC_BASE_DIV - 3'h1); // RL13
	assign done_o = en_i && cnt_r == ratio_i; // RL13

	always_ff @(posedge clk_i) begin
		if (!nrst_i || !en_i)
			pre_r <= 2'h0;
		else if (strobe_i)
			pre_r <= pre_r + 2'h1;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i || !en_i)
			cnt_r <= 8'h00;
		else if (tick && !done_o)
			cnt_r <= cnt_r + 8'h01;
	end

	default clocking tcb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_tick_gap: assert property (tick |=> !tick [*3])
		else $error("base tick faster than four strobes"); // RL13
	a_ratio_zero: assert property ((en_i && ratio_i == 8'h00) |-> done_o)
		else $error("zero ratio did not end the delay at once"); // RL13
endmodule // agc_freeze_timer
`default_nettype wire

// ### agc_loop_ctrl.sv
/*
 Top of the gain loop control block: configuration registers over
 AXI4-Lite, start/freeze sequencing of the loop and decoded settings.
 Assumes all receiver events are single-cycle pulses synchronous to
 clk_i, and that the low coefficient byte and freeze delay ratio come
 from registers kept elsewhere.
*/
// Added by the designer: register access over AXI4-Lite.
// Notes on behaviour
// (RL1) Integrator 2 gain is high nibble joined above low coefficient byte.
// (RL2) Attack factor code n means a shift of n plus one.
// (RL3) Decay factor code n means a shift of n plus two, beside attack.
// (RL4) Restart enable re-arms loop at each configuration start in polling.
// (RL5) Restart enable also re-arms loop on hold exit in slave run; the code re-arms there only while pll_hold_init_i is high.
// (RL6) Freeze codes one to three freeze after delay following event.
// (RL7) Freeze code four freezes only on software manual freeze command.
// (RL8) Software should pick the same level criterion as wake-up.
// (RL9) Start code selects off, direct, RSSI event or recognition event.
// (RL10) Gain correction is 14.5 dB plus half dB per code step.
// (RL11) Hysteresis is 12.8, 17.1, 21.3 or 25.6 dB by code.
// (RL12) Gain code fixes 0, -15, -30 dB or selects automatic gain.
// (RL13) Freeze delay counts ratio base ticks of four predecimation strobes.
// (RL14) A frozen loop holds gain until restart or new start.
`timescale 1ns/1ps
`default_nettype none
`include "agc_defs.svh"
module agc_loop_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output agc_pkg::agc_resp_t s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output agc_pkg::agc_resp_t s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Settings kept elsewhere
	input wire logic [7:0] integ2_coef_low_i,
	input wire logic [7:0] freeze_delay_ratio_i,
	input wire logic manual_gain_freeze_i,
	input wire logic pll_hold_init_i,
	// Receiver sequencing and events
	input wire logic self_polling_i,
	input wire logic config_start_i,
	input wire logic slave_run_i,
	input wire logic hold_exit_i,
	input wire logic rssi_event_i,
	input wire logic sig_recog_i,
	input wire logic symbol_sync_i,
	input wire logic predec_strobe_i,
	// Decoded settings
	output logic [11:0] integ2_coef_o,
	output logic [3:0] peak_attack_shift_o,
	output logic [3:0] peak_decay_shift_o,
	output logic [5:0] rssi_gain_corr_o,
	output logic [8:0] hysteresis_o,
	output logic gain_auto_o,
	output logic [4:0] gain_atten_o,
	// Loop state
	output logic loop_active_o,
	output logic loop_frozen_o
);
	import agc_pkg::*;

	agc_cfg_if cfg();
	agc_state_t state_r, state_nxt, arm_state;
	logic [2:0] up_code, dn_code, frz_code, dgc_code;
	logic [1:0] start_code, hys_code, gain_code;
	logic restart_en, cfg_restart, hold_restart, restart;
	logic start_hit, frz_event, frz_delayed, frz_manual, delay_done;
	logic active_r, frozen_r;

	agc_axil_regs u_regs (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.cfg(cfg.regs)
	);

	agc_freeze_timer u_timer (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.en_i(state_r == st_delay),
		.strobe_i(predec_strobe_i),
		.ratio_i(freeze_delay_ratio_i),
		.done_o(delay_done)
	);

	assign up_code = cfg.peak[`AGC_UP_MSB:`AGC_UP_LSB];
	assign dn_code = cfg.peak[`AGC_DN_MSB:`AGC_DN_LSB];
	assign restart_en = cfg.sf[`AGC_RESTART_BIT];
	assign frz_code = cfg.sf[`AGC_FRZ_MSB:`AGC_FRZ_LSB];
	assign start_code = cfg.sf[`AGC_START_MSB:`AGC_START_LSB];
	assign dgc_code = cfg.cfg0[`AGC_DGC_MSB:`AGC_DGC_LSB];
	assign hys_code = cfg.cfg0[`AGC_HYS_MSB:`AGC_HYS_LSB];
	assign gain_code = cfg.cfg0[`AGC_GAIN_MSB:`AGC_GAIN_LSB];

	assign cfg_restart = restart_en && self_polling_i &&
		config_start_i; // RL4
	assign hold_restart = restart_en && pll_hold_init_i && slave_run_i &&
		hold_exit_i; // RL5
	assign restart = cfg_restart || hold_restart;

	always_comb begin
		unique case (start_code)
			`AGC_START_OFF: start_hit = 1'b0; // RL9
			`AGC_START_DIRECT: start_hit = 1'b1; // RL9
			`AGC_START_RSSI: start_hit = rssi_event_i; // RL9
			`AGC_START_RECOG: start_hit = sig_recog_i; // RL9
		endcase
	end

	// Unused freeze codes behave as stay on
	always_comb begin
		frz_event = 1'b0;
		frz_delayed = 1'b0;
		frz_manual = 1'b0;
		unique case (frz_code)
			`AGC_FRZ_STAY: frz_event = 1'b0; // RL6
			`AGC_FRZ_RSSI: begin
				frz_delayed = 1'b1;
				frz_event = rssi_event_i; // RL6
			end
			`AGC_FRZ_RECOG: begin
				frz_delayed = 1'b1;
				frz_event = sig_recog_i; // RL6
			end
			`AGC_FRZ_SYNC: begin
				frz_delayed = 1'b1;
				frz_event = symbol_sync_i; // RL6
			end
			`AGC_FRZ_MANUAL: frz_manual = 1'b1; // RL7
			default: frz_event = 1'b0;
		endcase
	end

	assign arm_state = (start_code == `AGC_START_DIRECT) ? st_run : st_wait;

	// A write to the start/freeze register re-arms the loop as a new start
	always_comb begin
		state_nxt = state_r;
		if (start_code == `AGC_START_OFF) begin
			state_nxt = st_off; // RL9
		end else if (restart || cfg.sf_wr || state_r == st_off) begin
			state_nxt = arm_state; // RL4 RL5
		end else begin
			unique case (state_r)
				st_wait: if (start_hit) state_nxt = st_run; // RL9
				st_run: begin
					if (frz_manual && manual_gain_freeze_i)
						state_nxt = st_frozen; // RL7
					else if (frz_delayed && frz_event)
						state_nxt = st_delay; // RL6
				end
				st_delay: if (delay_done) state_nxt = st_frozen; // RL13
				st_off, st_frozen: state_nxt = state_r; // RL14
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			state_r <= st_off;
		else
			state_r <= state_nxt;
	end

	// Delay state still adapts gain; only frozen holds it
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			active_r <= 1'b0;
			frozen_r <= 1'b0;
		end else begin
			active_r <= state_nxt == st_run || state_nxt == st_delay;
			frozen_r <= state_nxt == st_frozen; // RL14
		end
	end

	assign loop_active_o = active_r;
	assign loop_frozen_o = frozen_r;
	assign cfg.status = {4'h0, state_r == st_delay, state_r == st_wait,
		frozen_r, active_r};

	// Decoded settings follow the registers one cycle later
	always_ff @(posedge clk_i) begin
		integ2_coef_o <= {cfg.k2hi[`AGC_K2HI_MSB:`AGC_K2HI_LSB],
			integ2_coef_low_i}; // RL1
		peak_attack_shift_o <= {1'b0, up_code} + `AGC_UP_OFS; // RL2
		peak_decay_shift_o <= {1'b0, dn_code} + `AGC_DN_OFS; // RL3
		rssi_gain_corr_o <= `AGC_DGC_BASE + {3'h0, dgc_code}; // RL10
	end

	always_ff @(posedge clk_i) begin
		unique case (hys_code)
			2'h0: hysteresis_o <= `AGC_HYS_0; // RL11
			2'h1: hysteresis_o <= `AGC_HYS_1; // RL11
			2'h2: hysteresis_o <= `AGC_HYS_2; // RL11
			2'h3: hysteresis_o <= `AGC_HYS_3; // RL11
		endcase
	end

	always_ff @(posedge clk_i) begin
		gain_auto_o <= gain_code == `AGC_GAIN_AUTO; // RL12
		unique case (gain_code)
			`AGC_GAIN_0DB: gain_atten_o <= `AGC_ATTEN_0; // RL12
			`AGC_GAIN_15DB: gain_atten_o <= `AGC_ATTEN_15; // RL12
			`AGC_GAIN_30DB: gain_atten_o <= `AGC_ATTEN_30; // RL12
			`AGC_GAIN_AUTO: gain_atten_o <= `AGC_ATTEN_0; // RL12
		endcase
	end

	default clocking mcb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	a_coef_join: assert property (integ2_coef_o[7:0] ==
		$past(integ2_coef_low_i) && integ2_coef_o[11:8] ==
		$past(cfg.k2hi[3:0]))
		else $error("integrator gain not joined"); // RL1
	a_attack_shift: assert property (peak_attack_shift_o ==
		{1'b0, $past(up_code)} + 4'h1)
		else $error("attack shift wrong"); // RL2
	a_decay_shift: assert property (peak_decay_shift_o ==
		{1'b0, $past(dn_code)} + 4'h2)
		else $error("decay shift wrong"); // RL3
	a_cfg_restart: assert property ((cfg_restart &&
		start_code == `AGC_START_DIRECT) |=> loop_active_o)
		else $error("config start restart missed"); // RL4
	a_hold_restart: assert property ((restart_en && pll_hold_init_i &&
		slave_run_i && hold_exit_i && start_code != `AGC_START_OFF)
		|=> state_r == $past(arm_state) && !loop_frozen_o)
		else $error("hold exit restart missed"); // RL5
	a_stay_on: assert property ((state_r == st_run &&
		frz_code == `AGC_FRZ_STAY && !restart && !cfg.sf_wr &&
		start_code != `AGC_START_OFF) |=> state_r == st_run &&
		loop_active_o)
		else $error("stay on code left run"); // RL6
	a_manual_frz: assert property ((state_r == st_run && frz_manual &&
		manual_gain_freeze_i && !restart && !cfg.sf_wr &&
		start_code != `AGC_START_OFF) |=> loop_frozen_o)
		else $error("manual freeze not taken"); // RL7
	a_start_off: assert property (start_code == `AGC_START_OFF |=>
		!loop_active_o && !loop_frozen_o)
		else $error("loop not off"); // RL9
	a_gain_corr: assert property (rssi_gain_corr_o ==
		6'h1d + {3'h0, $past(dgc_code)})
		else $error("gain correction wrong"); // RL10
	a_hys_top: assert property ($past(hys_code) == 2'h3 |->
		hysteresis_o == 9'h100)
		else $error("top hysteresis wrong"); // RL11
	a_gain_auto: assert property (gain_auto_o ==
		($past(gain_code) == 2'h3) && (($past(gain_code) == 2'h2) ->
		gain_atten_o == 5'h1e))
		else $error("gain selection wrong"); // RL12
	a_delay_zero: assert property ((state_r == st_run && frz_delayed &&
		frz_event && freeze_delay_ratio_i == 8'h00 && !restart &&
		!cfg.sf_wr && start_code != `AGC_START_OFF) ##1
		($stable(cfg.sf) && !restart && !cfg.sf_wr &&
		freeze_delay_ratio_i == 8'h00) |=> loop_frozen_o)
		else $error("zero delay freeze late"); // RL13
	a_frozen_hold: assert property ((state_r == st_frozen && !restart &&
		!cfg.sf_wr && start_code != `AGC_START_OFF) |=> loop_frozen_o)
		else $error("frozen loop released"); // RL14

	c_delay_freeze: cover property (state_r == st_delay ##1
		state_r == st_frozen);
	c_manual_freeze: cover property (state_r == st_run && frz_manual ##1
		state_r == st_frozen);
	c_restart_frozen: cover property (state_r == st_frozen && restart);
	c_event_start: cover property (state_r == st_wait ##1
		state_r == st_run);
endmodule // agc_loop_ctrl
`default_nettype wire

// ### tb.sv
/*
 Self-checking bench for the gain loop control top: registers over
 AXI4-Lite, decoded settings, start/freeze sequencing of the loop.
 Assumes the register indices and codes of agc_defs.svh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "agc_defs.svh"
module tb;
	import agc_pkg::*;
	typedef struct packed {
		logic [9:0] idx;
		logic [7:0] d;
		logic [7:0] r;
	} agc_row_t;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	// Response readies stay high all run: no lowering between transfers
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
	logic arvalid = 1'b0, rready = 1'b1;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	agc_resp_t bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] low = 8'h5a, ratio = 8'h00;
	logic pll_hold = 1'b0, polling = 1'b0, slave_run = 1'b0, strobe = 1'b0;
	// Pulses: rssi, recog, sync, manual, config start, hold exit
	logic [5:0] pv = 6'h00;
	logic [11:0] integ2;
	logic [3:0] att_sh, dec_sh;
	logic [5:0] corr;
	logic [8:0] hys;
	logic g_auto, active, frozen;
	logic [4:0] atten;
	int fail_count = 0;
	int total_checks = 0;
	logic [7:0] pk, sf, cf, k2;
	logic [8:0] hys_tab [4] = '{9'h080, 9'h0ab, 9'h0d5, 9'h100};
	logic [4:0] att_tab [4] = '{5'h00, 5'h0f, 5'h1e, 5'h00};
	agc_row_t rows [10] = '{
		'{`AGC_IDX_K2HI, 8'hff, 8'h0f}, '{`AGC_IDX_K2HI, 8'ha5, 8'h05},
		'{`AGC_IDX_PEAK, 8'hff, 8'h77}, '{`AGC_IDX_PEAK, 8'h00, 8'h00},
		'{`AGC_IDX_PEAK, 8'hb5, 8'h35}, '{`AGC_IDX_CFG0, 8'hff, 8'h7f},
		'{`AGC_IDX_CFG0, 8'h00, 8'h00}, '{`AGC_IDX_CFG0, 8'h15, 8'h15},
		'{`AGC_IDX_CFG0, 8'ha6, 8'h26}, '{`AGC_IDX_SF, 8'hc0, 8'h00}};

	always #25 clk_i = ~clk_i;

	agc_loop_ctrl u_agc_loop_ctrl (.clk_i(clk_i), .nrst_i(nrst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .integ2_coef_low_i(low),
		.freeze_delay_ratio_i(ratio), .manual_gain_freeze_i(pv[3]),
		.pll_hold_init_i(pll_hold), .self_polling_i(polling),
		.config_start_i(pv[4]), .slave_run_i(slave_run),
		.hold_exit_i(pv[5]), .rssi_event_i(pv[0]), .sig_recog_i(pv[1]),
		.symbol_sync_i(pv[2]), .predec_strobe_i(strobe),
		.integ2_coef_o(integ2), .peak_attack_shift_o(att_sh),
		.peak_decay_shift_o(dec_sh), .rssi_gain_corr_o(corr),
		.hysteresis_o(hys), .gain_auto_o(g_auto), .gain_atten_o(atten),
		.loop_active_o(active), .loop_frozen_o(frozen));

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic pulse(input logic [5:0] m);
		pv <= m;
		@(posedge clk_i);
		pv <= 6'h00;
	endtask

	// Both channels offered together; only the watchdog ends a wait
	task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d,
		input agc_resp_t er);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h5a5a5a, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (aw && w && bvalid) break;
			if (!aw && awready) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		chk("bresp", 32'(er), 32'(bresp));
	endtask

	task automatic axi_rd(input logic [9:0] idx, input logic [7:0] ed,
		input agc_resp_t er);
		logic ar;
		ar = 1'b0;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (ar && rvalid) break;
			if (!ar && arready) begin
				ar = 1'b1;
				arvalid <= 1'b0;
			end
		end
		chk("rdata", {24'h0, ed}, rdata);
		chk("rresp", 32'(er), 32'(rresp));
	endtask

	task automatic check_dec();
		chk("integ2", {20'h0, k2[3:0], low}, 32'(integ2));
		chk("attack", 32'(pk[6:4]) + 1, 32'(att_sh));
		chk("decay", 32'(pk[2:0]) + 2, 32'(dec_sh));
		chk("corr", 32'(cf[6:4]) + 29, 32'(corr));
		chk("hys", 32'(hys_tab[cf[3:2]]), 32'(hys));
		chk("auto", 32'(cf[1:0] == 2'h3), 32'(g_auto));
		chk("atten", 32'(att_tab[cf[1:0]]), 32'(atten));
	endtask

	task automatic flags(input logic a, input logic f);
		chk("active", 32'(a), 32'(active));
		chk("frozen", 32'(f), 32'(frozen));
	endtask

	task automatic do_reset();
		nrst_i <= 1'b0;
		tick(4);
		nrst_i <= 1'b1;
		tick(1);
		pk = 8'h42;
		sf = 8'h00;
		cf = 8'h2b;
		k2 = 8'h00;
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#(50 * 20000);
		fail_count++;
		finish_test();
	end

	initial begin
		int n;
		logic [2:0] hit;
		do_reset();
		for (int i = 0; i < 10; i++) begin
			axi_wr(rows[i].idx, rows[i].d, `AGC_RESP_OKAY);
			axi_rd(rows[i].idx, rows[i].r, `AGC_RESP_OKAY);
			case (rows[i].idx)
				`AGC_IDX_K2HI: k2 = rows[i].r;
				`AGC_IDX_PEAK: pk = rows[i].r;
				`AGC_IDX_CFG0: cf = rows[i].r;
				default: sf = rows[i].r;
			endcase
			check_dec();
		end
		$display("test register table done");
		axi_wr(10'h020, 8'h11, `AGC_RESP_SLVERR);
		axi_rd(10'h020, 8'h00, `AGC_RESP_SLVERR);
		axi_wr(`AGC_IDX_STAT, 8'h03, `AGC_RESP_SLVERR);
		$display("test unmapped done");
		// Every freeze code; ratio zero so a delay ends at once
		for (int c = 0; c < 8; c++) begin
			hit = (c >= 1 && c <= 3) ? 3'(3'b001 << (c - 1)) : 3'b000;
			axi_wr(`AGC_IDX_SF, 8'((c << 2) | 1), `AGC_RESP_OKAY);
			tick(3);
			pulse({3'b000, 3'b111 ^ hit});
			tick(2);
			flags(1'b1, 1'b0);
			pulse(6'h07);
			tick(3);
			flags(hit == 3'b000, hit != 3'b000);
		end
		$display("test freeze codes done");
		axi_wr(`AGC_IDX_SF, 8'h11, `AGC_RESP_OKAY);
		tick(3);
		pulse(6'h08);
		tick(1);
		flags(1'b0, 1'b1);
		pulse(6'h37);
		tick(3);
		flags(1'b0, 1'b1);
		axi_rd(`AGC_IDX_STAT, 8'h02, `AGC_RESP_OKAY);
		axi_wr(`AGC_IDX_SF, 8'h00, `AGC_RESP_OKAY);
		tick(3);
		flags(1'b0, 1'b0);
		$display("test manual freeze done");
		axi_wr(`AGC_IDX_SF, 8'h03, `AGC_RESP_OKAY);
		tick(3);
		pulse(6'h05);
		tick(2);
		flags(1'b0, 1'b0);
		axi_rd(`AGC_IDX_STAT, 8'h04, `AGC_RESP_OKAY);
		pulse(6'h02);
		tick(1);
		flags(1'b1, 1'b0);
		$display("test start codes done");
		// Delay of two base ticks with a strobe every cycle
		ratio <= 8'h02;
		axi_wr(`AGC_IDX_SF, 8'h06, `AGC_RESP_OKAY);
		tick(3);
		pulse(6'h01);
		tick(1);
		flags(1'b1, 1'b0);
		pulse(6'h01);
		strobe <= 1'b1;
		n = 0;
		while (frozen !== 1'b1 && n < 30) begin
			tick(1);
			n++;
		end
		strobe <= 1'b0;
		chk("delay span", 32'h1, 32'(n >= 8 && n <= 11));
		$display("test freeze delay done");
		ratio <= 8'h00;
		axi_wr(`AGC_IDX_SF, 8'h25, `AGC_RESP_OKAY);
		tick(3);
		pulse(6'h01);
		tick(3);
		flags(1'b0, 1'b1);
		pulse(6'h10);
		tick(2);
		flags(1'b0, 1'b1);
		polling <= 1'b1;
		pulse(6'h10);
		tick(1);
		flags(1'b1, 1'b0);
		pulse(6'h01);
		tick(3);
		polling <= 1'b0;
		slave_run <= 1'b1;
		pulse(6'h20);
		tick(2);
		flags(1'b0, 1'b1);
		pll_hold <= 1'b1;
		pulse(6'h20);
		tick(1);
		flags(1'b1, 1'b0);
		$display("test restart done");
		low <= 8'hc3;
		do_reset();
		flags(1'b0, 1'b0);
		axi_rd(`AGC_IDX_K2HI, 8'h00, `AGC_RESP_OKAY);
		axi_rd(`AGC_IDX_PEAK, 8'h42, `AGC_RESP_OKAY);
		axi_rd(`AGC_IDX_SF, 8'h00, `AGC_RESP_OKAY);
		axi_rd(`AGC_IDX_CFG0, 8'h2b, `AGC_RESP_OKAY);
		check_dec();
		$display("test reset done");
		finish_test();
	end
endmodule // tb
`default_nettype wire
